// file: verilog/msc_regs.sv
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - status one bits 15:8 hold the last executed serial command code.
// - status one bit 3 flags voltage-two, bit 2 voltage-one modulator oscillation.
// - status one bit 1 flags current-two, bit 0 current-one modulator oscillation.
// - status two bits 5:0 are power sign flags, one means negative; rest reserved.
// - line/sample ratio is a signed fraction resetting to 0x01999a.
// - ratio is host written, or device computed while automatic frequency is on.
// - no-load threshold is a signed fraction, reset zero, used as anti-creep limit.
// - both summed active and reactive below threshold forces both to zero.
// - summed apparent below threshold forces it to zero.
// - low-rate period counts output-word-rate samples up to the sample total.
// - in line-cycle mode the period counts half line cycles up to cycle total.
// - each completed low-rate update raises the data-ready flag.
// - each device update of the ratio raises the frequency-updated flag.
module msc_regs
(
    // clock and reset
    input  wire logic                core_clk_i,
    input  wire logic                rstn_i,
    // register access from the serial port
    input  wire msc_pkg::msc_req_type reg_req_i,
    output logic [23:0]              rd_data_o,
    output logic                     rd_valid_o,
    // command and modulator status
    input  wire logic                cmd_exec_i,
    input  wire logic [7:0]          cmd_code_i,
    input  wire logic [3:0]          osc_detect_i,
    // configuration bits from config_reg_two and mode
    input  wire logic                auto_freq_calc_i,
    input  wire logic                line_sync_mode_i,
    // timing strobes
    input  wire logic                owr_tick_i,
    input  wire logic                half_cycle_tick_i,
    // automatic ratio estimate
    input  wire logic                freq_est_valid_i,
    input  wire logic [23:0]         freq_est_i,
    // averaged results
    input  wire logic                avg_valid_i,
    input  wire msc_pkg::msc_avg_type avg_i,
    // raw summed results
    input  wire logic                sum_valid_i,
    input  wire msc_pkg::msc_sum_type sum_i,
    // outputs to the engine and flag logic
    output msc_pkg::msc_sum_type     sum_o,
    output logic                     sum_valid_o,
    output logic [23:0]              line_sample_ratio_o,
    output logic                     low_rate_end_o,
    output logic                     low_rate_ready_flag_o,
    output logic                     freq_updated_flag_o
);
    import msc_pkg::*;

    // ******************************************************
    // state
    // ******************************************************
    typedef struct packed {
        logic [23:0]  chip_status_one;
        logic [23:0]  power_sign_status;
        logic [23:0]  line_sample_ratio;
        logic [23:0]  low_rate_sample_total;
        logic [23:0]  no_load_threshold;
        logic [23:0]  half_cycle_total;
        logic [22:0]  period_cnt;
        logic [23:0]  rd_data;
        logic         rd_valid;
        msc_sum_type  sum;
        logic         sum_valid;
        logic         low_rate_end;
        logic         ready_flag;
        logic         freq_flag;
    } msc_state_type;

    msc_state_type state_ff;
    msc_state_type nxt_state;

    // magnitude of a signed fraction; most negative saturates one step short
    function automatic logic [23:0] msc_mag(input logic [23:0] v);
        logic [23:0] neg;
        neg = 24'h000000 - v;
        if (!v[23])
            msc_mag = v;
        else if (neg[23])
            msc_mag = 24'h7fffff;
        else
            msc_mag = neg;
    endfunction

    // ******************************************************
    // next state
    // ******************************************************
    logic [22:0] cnt_inc;
    logic        period_tick;
    logic [22:0] period_limit;
    logic        pq_creep;
    logic        s_creep;
    logic [23:0] thr;

    // pick the period source and test the anti-creep limits
    always_comb
    begin
        thr          = state_ff.no_load_threshold;
        period_tick  = line_sync_mode_i ? half_cycle_tick_i : owr_tick_i;
        period_limit = line_sync_mode_i ? state_ff.half_cycle_total[22:0]
                                        : state_ff.low_rate_sample_total[22:0];
        cnt_inc      = state_ff.period_cnt + 23'h000001;
        pq_creep     = (msc_mag(sum_i.active) < thr) && (msc_mag(sum_i.react) < thr);
        s_creep      = msc_mag(sum_i.apparent) < thr;
    end

    // register behaviour
    always_comb
    begin
        nxt_state              = state_ff;
        nxt_state.rd_valid     = 1'b0;
        nxt_state.sum_valid    = 1'b0;
        nxt_state.low_rate_end = 1'b0;
        nxt_state.ready_flag   = 1'b0;
        nxt_state.freq_flag    = 1'b0;

        // status one: command code and live oscillation flags
        if (cmd_exec_i)
            nxt_state.chip_status_one[MSC_LAST_CMD_LSB +: 8] = cmd_code_i;
        nxt_state.chip_status_one[3:2] = osc_detect_i[3:2];
        nxt_state.chip_status_one[1:0] = osc_detect_i[1:0];

        // host writes; the two status registers take none
        if (reg_req_i.wr)
        begin
            unique case (reg_req_i.addr)
                MSC_OFS_LINE_SAMPLE_RATIO:
                    if (!auto_freq_calc_i)
                        nxt_state.line_sample_ratio = reg_req_i.wdata;
                MSC_OFS_LOW_RATE_SAMPLES:
                    nxt_state.low_rate_sample_total = {1'b0, reg_req_i.wdata[22:0]};
                MSC_OFS_NO_LOAD_THRESHOLD:
                    nxt_state.no_load_threshold = reg_req_i.wdata;
                MSC_OFS_HALF_CYCLE_TOTAL:
                    nxt_state.half_cycle_total = {1'b0, reg_req_i.wdata[22:0]};
                default:
                    nxt_state.rd_valid = 1'b0; // status and unmapped writes dropped
            endcase
        end

        // automatic ratio wins the register while enabled
        if (auto_freq_calc_i && freq_est_valid_i)
        begin
            nxt_state.line_sample_ratio = freq_est_i;
            nxt_state.freq_flag         = 1'b1;
        end

        // host reads, answered one cycle later
        if (reg_req_i.rd)
        begin
            nxt_state.rd_valid = 1'b1;
            unique case (reg_req_i.addr)
                MSC_OFS_CHIP_STATUS_ONE:   nxt_state.rd_data = state_ff.chip_status_one;
                MSC_OFS_POWER_SIGN_STATUS: nxt_state.rd_data = state_ff.power_sign_status;
                MSC_OFS_LINE_SAMPLE_RATIO: nxt_state.rd_data = state_ff.line_sample_ratio;
                MSC_OFS_LOW_RATE_SAMPLES:  nxt_state.rd_data = state_ff.low_rate_sample_total;
                MSC_OFS_NO_LOAD_THRESHOLD: nxt_state.rd_data = state_ff.no_load_threshold;
                MSC_OFS_HALF_CYCLE_TOTAL:  nxt_state.rd_data = state_ff.half_cycle_total;
                default:                   nxt_state.rd_data = 24'h000000;
            endcase
        end

        // low-rate period; a limit of zero is host misuse and acts as one
        if (period_tick)
        begin
            if (cnt_inc >= period_limit)
            begin
                nxt_state.period_cnt   = MSC_CNT_ZERO;
                nxt_state.low_rate_end = 1'b1;
            end
            else
                nxt_state.period_cnt = cnt_inc;
        end

        // averaged signs follow each averaged update
        if (avg_valid_i)
        begin
            nxt_state.power_sign_status[0] = avg_i.active_one[23];
            nxt_state.power_sign_status[1] = avg_i.active_two[23];
            nxt_state.power_sign_status[3] = avg_i.react_one[23];
            nxt_state.power_sign_status[4] = avg_i.react_two[23];
            nxt_state.ready_flag           = 1'b1;
        end

        // summed results pass anti-creep, then give their signs
        if (sum_valid_i)
        begin
            nxt_state.sum       = sum_i;
            nxt_state.sum_valid = 1'b1;
            if (pq_creep)
            begin
                nxt_state.sum.active = 24'h000000;
                nxt_state.sum.react  = 24'h000000;
            end
            if (s_creep)
                nxt_state.sum.apparent = 24'h000000;
            nxt_state.power_sign_status[2] = sum_i.active[23] && !pq_creep;
            nxt_state.power_sign_status[5] = sum_i.react[23] && !pq_creep;
        end
        nxt_state.power_sign_status[23:6] = 18'h00000;
    end

    // ******************************************************
    // registers
    // ******************************************************
    // one flop bank; reset loads constants only
    always_ff @(posedge core_clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_ff                       <= '0;
            state_ff.chip_status_one       <= MSC_RST_CHIP_STATUS_ONE;
            state_ff.power_sign_status     <= MSC_RST_POWER_SIGN_STATUS;
            state_ff.line_sample_ratio     <= MSC_RST_LINE_SAMPLE_RATIO;
            state_ff.low_rate_sample_total <= MSC_RST_LOW_RATE_SAMPLES;
            state_ff.no_load_threshold     <= MSC_RST_NO_LOAD_THRESHOLD;
            state_ff.half_cycle_total      <= MSC_RST_HALF_CYCLE_TOTAL;
        end
        else
            state_ff <= nxt_state;
    end

    // outputs straight from the flop bank
    assign rd_data_o             = state_ff.rd_data;
    assign rd_valid_o            = state_ff.rd_valid;
    assign sum_o                 = state_ff.sum;
    assign sum_valid_o           = state_ff.sum_valid;
    assign line_sample_ratio_o   = state_ff.line_sample_ratio;
    assign low_rate_end_o        = state_ff.low_rate_end;
    assign low_rate_ready_flag_o = state_ff.ready_flag;
    assign freq_updated_flag_o   = state_ff.freq_flag;

endmodule // msc_regs
`default_nettype wire

// file: verilog/msc_pkg.sv
`default_nettype none
package msc_pkg;

    // ******************************************************
    // register offsets (serial port register numbers)
    // ******************************************************
    localparam logic [5:0] MSC_OFS_CHIP_STATUS_ONE   = 6'h18;
    localparam logic [5:0] MSC_OFS_POWER_SIGN_STATUS = 6'h19;
    localparam logic [5:0] MSC_OFS_LINE_SAMPLE_RATIO = 6'h31;
    localparam logic [5:0] MSC_OFS_LOW_RATE_SAMPLES  = 6'h33;
    localparam logic [5:0] MSC_OFS_NO_LOAD_THRESHOLD = 6'h3a;
    localparam logic [5:0] MSC_OFS_HALF_CYCLE_TOTAL  = 6'h3e;

    // ******************************************************
    // reset values
    // ******************************************************
    localparam logic [23:0] MSC_RST_CHIP_STATUS_ONE   = 24'h801800;
    localparam logic [23:0] MSC_RST_POWER_SIGN_STATUS = 24'h000000;
    localparam logic [23:0] MSC_RST_LINE_SAMPLE_RATIO = 24'h01999a;
    localparam logic [23:0] MSC_RST_LOW_RATE_SAMPLES  = 24'h000fa0;
    localparam logic [23:0] MSC_RST_NO_LOAD_THRESHOLD = 24'h000000;
    localparam logic [23:0] MSC_RST_HALF_CYCLE_TOTAL  = 24'h000064;

    // ******************************************************
    // field positions
    // ******************************************************
    localparam int MSC_LAST_CMD_LSB  = 8;  // last_command_code in [15:8]
    localparam int MSC_COUNT_TOP_BIT = 23; // count registers keep this bit zero
    localparam logic [22:0] MSC_CNT_ZERO = 23'h000000;

    // ******************************************************
    // carriers
    // ******************************************************
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [5:0]  addr;
        logic [23:0] wdata;
    } msc_req_type;

    // averaged results of both channels
    typedef struct packed {
        logic [23:0] active_one;
        logic [23:0] active_two;
        logic [23:0] react_one;
        logic [23:0] react_two;
    } msc_avg_type;

    // summed results before or after anti-creep
    typedef struct packed {
        logic [23:0] active;
        logic [23:0] react;
        logic [23:0] apparent;
    } msc_sum_type;

endpackage : msc_pkg
`default_nettype wire

// file: test/msc_regs_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module msc_regs_assertions
(
    // clock, reset and register port
    input wire logic                 core_clk_i, rstn_i, rd_valid_o,
    input wire msc_pkg::msc_req_type reg_req_i,
    input wire logic [23:0]          rd_data_o, freq_est_i, line_sample_ratio_o,
    // status sources and results
    input wire logic [3:0]           osc_detect_i,
    input wire logic                 auto_freq_calc_i, freq_est_valid_i, avg_valid_i,
    input wire logic                 sum_valid_i, sum_valid_o, low_rate_ready_flag_o,
    input wire logic                 freq_updated_flag_o,
    input wire msc_pkg::msc_sum_type sum_i, sum_o
);
    import msc_pkg::*;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    // ************************************************
    // register reads
    // ************************************************
    sequence s_read(logic [5:0] a);
        reg_req_i.rd && reg_req_i.addr == a;
    endsequence
    a_read_answer: assert property (rd_valid_o == $past(reg_req_i.rd))
        else $error("read answer not one cycle after request");
    a_status_one_fixed: assert property (s_read(MSC_OFS_CHIP_STATUS_ONE) |=>
        rd_data_o[23:16] == 8'h80 && rd_data_o[7:4] == 4'h0) else $error("status one fixed bits");
    a_osc_flags: assert property (s_read(MSC_OFS_CHIP_STATUS_ONE) ##0 $stable(osc_detect_i)
        |=> rd_data_o[3:0] == $past(osc_detect_i)) else $error("oscillation flags wrong");
    a_sign_reserved: assert property (s_read(MSC_OFS_POWER_SIGN_STATUS) |=>
        rd_data_o[23:6] == 18'h0) else $error("sign register reserved bits set");
    a_count_top: assert property ((s_read(MSC_OFS_LOW_RATE_SAMPLES) or
        s_read(MSC_OFS_HALF_CYCLE_TOTAL)) |=> !rd_data_o[23]) else $error("count top bit set");
    // ************************************************
    // sums, flags and ratio
    // ************************************************
    a_sum_answer: assert property (sum_valid_o == $past(sum_valid_i))
        else $error("sum result not one cycle after input");
    a_creep_pair: assert property (sum_valid_i |=> (sum_o.active == 24'h0 &&
        sum_o.react == 24'h0) || (sum_o.active == $past(sum_i.active) &&
        sum_o.react == $past(sum_i.react))) else $error("active and reactive sums split");
    a_creep_app: assert property (sum_valid_i |=> sum_o.apparent == 24'h0 ||
        sum_o.apparent == $past(sum_i.apparent)) else $error("apparent sum altered");
    a_ready_pulse: assert property (low_rate_ready_flag_o == $past(avg_valid_i))
        else $error("data ready pulse mistimed");
    a_freq_flag: assert property (freq_updated_flag_o ==
        ($past(auto_freq_calc_i) && $past(freq_est_valid_i))) else $error("freq flag mistimed");
    a_ratio_auto: assert property (auto_freq_calc_i && freq_est_valid_i |=>
        line_sample_ratio_o == $past(freq_est_i)) else $error("ratio not taken from estimate");
endmodule // msc_regs_assertions
bind msc_regs msc_regs_assertions u_chk (.*);
`default_nettype wire

// file: test/msc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module msc_host_model
(
    // clock and read answer
    input  wire logic                 core_clk_i,
    input  wire logic [23:0]          rd_data_i,
    input  wire logic                 rd_valid_i,
    // register requests
    output var msc_pkg::msc_req_type  req_o
);
    import msc_pkg::*;
    initial req_o = '0;
    // one request edge; released lines show inverted values so stale data never matches
    task automatic issue(input logic w, input logic [5:0] a, input logic [23:0] d);
        @(posedge core_clk_i);
        req_o <= '{w, !w, a, d};
        @(posedge core_clk_i);
        req_o <= '{1'b0, 1'b0, ~a, ~d};
    endtask
    // host keeps the counts inside their legal ranges
    task automatic wr(input logic [5:0] a, input logic [23:0] d);
        logic [23:0] v;
        v = d;
        if (a == MSC_OFS_LOW_RATE_SAMPLES && v < 24'd100)
            v = 24'd100;
        if (a == MSC_OFS_HALF_CYCLE_TOTAL && v[22:0] == 23'h0)
            v = 24'h000001;
        issue(1'b1, a, v);
    endtask
    task automatic rd(input logic [5:0] a, output logic [23:0] d, output logic v);
        issue(1'b0, a, 24'h5a5a5a);
        @(posedge core_clk_i);
        d = rd_data_i;
        v = rd_valid_i;
    endtask
endmodule // msc_host_model
`default_nettype wire

// file: test/msc_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module msc_regs_tb;
    import msc_pkg::*;
    logic        core_clk_i = 1'b0, rstn_i = 1'b0, cmd_exec_i = 1'b0, auto_freq_calc_i = 1'b0;
    logic        line_sync_mode_i = 1'b0, owr_tick_i = 1'b0, half_cycle_tick_i = 1'b0;
    logic        freq_est_valid_i = 1'b0, avg_valid_i = 1'b0, sum_valid_i = 1'b0;
    logic [7:0]  cmd_code_i = 8'h00;
    logic [3:0]  osc_detect_i = 4'h0;
    logic [23:0] freq_est_i = 24'h000000, rd_data_o, line_sample_ratio_o;
    msc_avg_type avg_i = '0;
    msc_sum_type sum_i = '0, sum_o;
    msc_req_type reg_req_i;
    logic        rd_valid_o, sum_valid_o, low_rate_end_o, low_rate_ready_flag_o;
    logic        freq_updated_flag_o;
    int          bad_count = 0, n_tests = 0;
    always #20 core_clk_i = ~core_clk_i;
    msc_regs dut (.*);
    msc_host_model host (.core_clk_i(core_clk_i), .rd_data_i(rd_data_o),
        .rd_valid_i(rd_valid_o), .req_o(reg_req_i));
    // ************************************************
    // shared helpers
    // ************************************************
    task automatic check(input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("wrong value at %0t: %h instead of %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        if (bad_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic rd_chk(input logic [5:0] a, input logic [23:0] exp);
        logic [23:0] d;
        logic        v;
        host.rd(a, d, v);
        check({23'h0, v}, 24'h1);
        check(d, exp);
    endtask
    task automatic do_sum(input msc_sum_type s, input msc_sum_type exp);
        @(posedge core_clk_i);
        sum_valid_i <= 1'b1;
        sum_i <= s;
        @(posedge core_clk_i);
        sum_valid_i <= 1'b0;
        @(posedge core_clk_i);
        check({23'h0, sum_valid_o}, 24'h1);
        check(sum_o.active, exp.active);
        check(sum_o.react, exp.react);
        check(sum_o.apparent, exp.apparent);
    endtask
    // ************************************************
    // scenarios
    // ************************************************
    task automatic t_reset_ro();
        logic [5:0]  adr [6] = '{6'h18, 6'h19, 6'h31, 6'h33, 6'h3a, 6'h3e};
        logic [23:0] rst [6] = '{MSC_RST_CHIP_STATUS_ONE, MSC_RST_POWER_SIGN_STATUS,
            MSC_RST_LINE_SAMPLE_RATIO, MSC_RST_LOW_RATE_SAMPLES,
            MSC_RST_NO_LOAD_THRESHOLD, MSC_RST_HALF_CYCLE_TOTAL};
        for (int i = 0; i < 6; i++)
            rd_chk(adr[i], rst[i]);
        for (int i = 0; i < 2; i++)
        begin
            host.wr(adr[i], 24'hffffff);
            rd_chk(adr[i], rst[i]);
        end
        host.wr(6'h01, 24'hffffff);
        rd_chk(6'h01, 24'h000000);
    endtask
    task automatic t_cmd_osc(input logic [7:0] code, input logic [3:0] flags);
        @(posedge core_clk_i);
        cmd_exec_i <= 1'b1;
        cmd_code_i <= code;
        osc_detect_i <= flags;
        @(posedge core_clk_i);
        cmd_exec_i <= 1'b0;
        rd_chk(MSC_OFS_CHIP_STATUS_ONE, {8'h80, code, 4'h0, flags});
    endtask
    // negative results on active one, reactive two and summed active
    task automatic t_signs();
        @(posedge core_clk_i);
        avg_valid_i <= 1'b1;
        avg_i <= '{24'h800001, 24'h000001, 24'h000001, 24'hfffff0};
        @(posedge core_clk_i);
        avg_valid_i <= 1'b0;
        @(posedge core_clk_i);
        check({23'h0, low_rate_ready_flag_o}, 24'h1);
        do_sum('{24'hfffff0, 24'h000010, 24'h000010},
            '{24'hfffff0, 24'h000010, 24'h000010});
        rd_chk(MSC_OFS_POWER_SIGN_STATUS, 24'h000015);
    endtask
    // active exactly at threshold keeps the pair alive, apparent still creeps
    task automatic t_creep();
        host.wr(MSC_OFS_NO_LOAD_THRESHOLD, 24'h000100);
        rd_chk(MSC_OFS_NO_LOAD_THRESHOLD, 24'h000100);
        do_sum('{24'h0000ff, 24'hffff01, 24'h0000ff}, '0);
        rd_chk(MSC_OFS_POWER_SIGN_STATUS, 24'h000011);
        do_sum('{24'h000100, 24'hffff01, 24'h0000ff},
            '{24'h000100, 24'hffff01, 24'h0});
        rd_chk(MSC_OFS_POWER_SIGN_STATUS, 24'h000031);
    endtask
    task automatic t_ratio();
        host.wr(MSC_OFS_LINE_SAMPLE_RATIO, 24'h020000);
        rd_chk(MSC_OFS_LINE_SAMPLE_RATIO, 24'h020000);
        check(line_sample_ratio_o, 24'h020000);
        auto_freq_calc_i <= 1'b1;
        host.wr(MSC_OFS_LINE_SAMPLE_RATIO, 24'h123456);
        rd_chk(MSC_OFS_LINE_SAMPLE_RATIO, 24'h020000);
        freq_est_valid_i <= 1'b1;
        freq_est_i <= 24'h0147ae;
        @(posedge core_clk_i);
        freq_est_valid_i <= 1'b0;
        @(posedge core_clk_i);
        check({23'h0, freq_updated_flag_o}, 24'h1);
        rd_chk(MSC_OFS_LINE_SAMPLE_RATIO, 24'h0147ae);
        auto_freq_calc_i <= 1'b0;
    endtask
    // selected tick every other edge, the other tick stuck high: ends 2n edges apart
    task automatic t_period(input logic sync, input logic [5:0] a, input logic [23:0] wv,
        input int n);
        int e1 = 0;
        int e2 = 0;
        host.wr(a, wv);
        rd_chk(a, 24'(n));
        for (int k = 0; k < 4 * n + 8; k++)
        begin
            @(posedge core_clk_i);
            line_sync_mode_i <= sync;
            owr_tick_i <= sync | k[0];
            half_cycle_tick_i <= !sync | k[0];
            if (low_rate_end_o === 1'b1)
            begin
                e1 = e2;
                e2 = k;
            end
        end
        @(posedge core_clk_i);
        owr_tick_i <= 1'b0;
        half_cycle_tick_i <= 1'b0;
        check(24'(e2 - e1), 24'(2 * n));
    endtask
    // reset in mid-run must drop the counts and threshold written above
    task automatic t_mid_reset();
        @(posedge core_clk_i);
        rstn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        rd_chk(MSC_OFS_LOW_RATE_SAMPLES, MSC_RST_LOW_RATE_SAMPLES);
        rd_chk(MSC_OFS_HALF_CYCLE_TOTAL, MSC_RST_HALF_CYCLE_TOTAL);
        rd_chk(MSC_OFS_NO_LOAD_THRESHOLD, MSC_RST_NO_LOAD_THRESHOLD);
    endtask
    initial
    begin
        repeat (16) @(posedge core_clk_i);
        rstn_i <= 1'b1;
        t_reset_ro();
        t_cmd_osc(8'h5a, 4'ha);
        t_cmd_osc(8'ha5, 4'h5);
        t_signs();
        t_creep();
        t_ratio();
        t_period(1'b0, MSC_OFS_LOW_RATE_SAMPLES, 24'h000064, 100);
        t_period(1'b1, MSC_OFS_HALF_CYCLE_TOTAL, 24'h800003, 3);
        t_mid_reset();
        give_verdict();
    end
    // run needs under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge core_clk_i);
        bad_count++;
        give_verdict();
    end
endmodule // msc_regs_tb
`default_nettype wire
